// file: epus_top.sv
// top: power-up and delivery state of the serial eeprom control logic
`timescale 1ns/1ns
module epus_top #(
  parameter int WRITE_CYCLES = epus_pkg::WRITE_CYCLES
) (
  input wire logic MCLK_IN, // 10 MHz clock
  input wire logic RESET_N_IN, // power-up reset, active low
  input wire logic CHIP_SEL_N_IN, // select pin, active low
  input wire logic HOLD_N_IN, // hold pin, active low
  input wire logic WRITE_PROT_N_IN, // write protect pin, active low
  input wire logic FACTORY_INIT_IN, // pulse: load factory state
  input wire logic SET_LATCH_IN, // pulse: write enable decoded
  input wire logic CLR_LATCH_IN, // pulse: write disable decoded
  input wire logic WRITE_REQ_IN, // level: write instruction armed
  input wire logic STATUS_WR_IN, // pulse: status write decoded
  input wire epus_pkg::epus_nv_s STATUS_DATA_IN, // new nv bits
  input wire logic [15:0] ARRAY_ADDR_IN, // read address
  output logic [7:0] ARRAY_DATA_OUT, // read data
  output logic [7:0] STATUS_OUT, // status byte
  output logic STANDBY_OUT, // low-power standby
  output logic SELECTED_OUT, // instructions accepted
  output logic HOLD_ACTIVE_OUT, // paused in hold
  output logic STATUS_WR_OK_OUT // status write allowed
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic cs_n;
  logic hold_n;
  logic wp_n;

  // select path starts low: a select held through reset makes no fall,
  // and the false rise it gives after reset is ignored in standby
  epus_sync #(
    .INIT(1'b0)
  ) u_cs (
    .clk_in(MCLK_IN),
    .rst_n_in(RESET_N_IN),
    .pin_in(CHIP_SEL_N_IN),
    .level_out(cs_n)
  );
  epus_sync #(
    .INIT(1'b1)
  ) u_hold (
    .clk_in(MCLK_IN),
    .rst_n_in(RESET_N_IN),
    .pin_in(HOLD_N_IN),
    .level_out(hold_n)
  );
  epus_sync #(
    .INIT(1'b1)
  ) u_wp (
    .clk_in(MCLK_IN),
    .rst_n_in(RESET_N_IN),
    .pin_in(WRITE_PROT_N_IN),
    .level_out(wp_n)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  epus_pkg::epus_mode_e mode;
  epus_pkg::epus_mode_e next_mode;
  logic cs_n_d;
  logic armed;
  logic next_armed;
  logic latch;
  logic next_latch;
  logic busy;
  logic next_busy;
  logic hold;
  logic next_hold;
  logic [31:0] wcount;
  logic [31:0] next_wcount;
  // nv bits model non-volatile cells: reset never touches them
  epus_pkg::epus_nv_s nv;
  epus_pkg::epus_nv_s next_nv;
  logic wr_ok;

  wire cs_fall = cs_n_d & ~cs_n;
  wire cs_rise = ~cs_n_d & cs_n;

  // lock clear means the protect pin is ignored
  assign wr_ok = latch & (~nv.status_write_lock | wp_n);

  // select, write and hold sequencing
  always_comb begin
    next_mode = mode;
    next_armed = armed;
    next_latch = latch;
    next_busy = busy;
    next_hold = hold;
    next_wcount = wcount;
    if (cs_n) begin
      next_armed = 1'b0;
    end else if (cs_fall) begin
      next_armed = 1'b1;
    end
    if (armed && !cs_n) begin
      next_hold = ~hold_n;
    end else if (cs_n) begin
      next_hold = 1'b0;
    end
    if (SET_LATCH_IN && armed && !busy) begin
      next_latch = 1'b1;
    end else if (CLR_LATCH_IN && armed && !busy) begin
      next_latch = 1'b0;
    end
    case (mode)
      epus_pkg::EPUS_STANDBY: begin
        if (cs_fall) begin
          next_mode = epus_pkg::EPUS_ACTIVE;
        end
      end
      epus_pkg::EPUS_ACTIVE: begin
        if (cs_rise) begin
          if (WRITE_REQ_IN && latch) begin
            next_mode = epus_pkg::EPUS_WRITING;
            next_busy = 1'b1;
            next_wcount = 32'h0;
          end else begin
            next_mode = epus_pkg::EPUS_STANDBY;
          end
        end
      end
      epus_pkg::EPUS_WRITING: begin
        next_wcount = wcount + 32'h1;
        if (wcount >= WRITE_CYCLES - 1) begin
          next_busy = 1'b0;
          next_latch = 1'b0;
          next_mode = cs_n ? epus_pkg::EPUS_STANDBY
                           : epus_pkg::EPUS_ACTIVE;
        end
      end
      default: begin
        next_mode = epus_pkg::EPUS_STANDBY;
      end
    endcase
  end

  // power-up state; a select already low is not a falling edge
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      mode <= epus_pkg::EPUS_STANDBY;
      cs_n_d <= 1'b0; // matches the select sync start
      armed <= 1'b0;
      hold <= 1'b0;
      latch <= 1'b0;
      busy <= 1'b0;
      wcount <= 32'h0;
    end else begin
      mode <= next_mode;
      cs_n_d <= cs_n;
      armed <= next_armed;
      hold <= next_hold;
      latch <= next_latch;
      busy <= next_busy;
      wcount <= next_wcount;
    end
  end

  // ----------------------------------------------------------------
  // non-volatile bits
  // ----------------------------------------------------------------
  // factory load wins over a status write in the same cycle
  always_comb begin
    next_nv = nv;
    if (FACTORY_INIT_IN) begin
      next_nv = {epus_pkg::FACTORY_LOCK, epus_pkg::FACTORY_PROTECT};
    end else if (STATUS_WR_IN && wr_ok && armed && !busy) begin
      next_nv = STATUS_DATA_IN;
    end
  end

  // no reset branch: values persist across power cycles
  always_ff @(posedge MCLK_IN) begin
    nv <= next_nv;
  end

  // ----------------------------------------------------------------
  // array contents: delivery state only, programming lives elsewhere
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ARRAY_DATA_OUT <= epus_pkg::ERASED_BYTE;
    end else begin
      ARRAY_DATA_OUT <= epus_pkg::ERASED_BYTE;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic [7:0] status_byte;

  // status byte assembly; unused positions read as zero
  always_comb begin
    status_byte = 8'h00;
    status_byte[epus_pkg::STAT_BUSY] = busy;
    status_byte[epus_pkg::STAT_LATCH] = latch;
    status_byte[epus_pkg::STAT_PROT_LO] = nv.block_protect_lo;
    status_byte[epus_pkg::STAT_PROT_HI] = nv.block_protect_hi;
    status_byte[epus_pkg::STAT_LOCK] = nv.status_write_lock;
  end

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      STATUS_OUT <= 8'h00;
      STANDBY_OUT <= 1'b1;
      SELECTED_OUT <= 1'b0;
      HOLD_ACTIVE_OUT <= 1'b0;
      STATUS_WR_OK_OUT <= 1'b0;
    end else begin
      STATUS_OUT <= status_byte;
      STANDBY_OUT <= (mode == epus_pkg::EPUS_STANDBY);
      SELECTED_OUT <= armed;
      HOLD_ACTIVE_OUT <= hold;
      STATUS_WR_OK_OUT <= wr_ok;
    end
  end
endmodule

// file: epus_pkg.sv
// package: constants and carriers for the eeprom power-up state logic
// ----------------------------------------------------------------------
// Behaviour
// - after power-up the device sits in standby until the host selects it
// - starts deselected; needs a select falling edge before any instruction
// - never starts paused in hold, whatever hold did before
// - power-up clears the write enable latch to 0
// - power-up clears the write cycle busy flag to 0
// - lock and both protect bits keep their values across power cycles
// - factory state: every array byte reads as all ones
// - factory state: lock and both protect bits are 0
// - busy flag clears to 0 when the self-timed write ends
// - lock at 0 lets status writes through whenever latch is set, the device is selected and no write is busy
// ----------------------------------------------------------------------
package epus_pkg;
  localparam int CLK_HZ = 10_000_000;
  // write time in microseconds, longest
  localparam int WRITE_TIME_US = 5000;
  localparam int WRITE_CYCLES = (WRITE_TIME_US * (CLK_HZ / 1_000_000));
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic FACTORY_LOCK = 1'b0;
  localparam logic [1:0] FACTORY_PROTECT = 2'h0;
  // status byte field positions
  localparam int STAT_BUSY = 0;
  localparam int STAT_LATCH = 1;
  localparam int STAT_PROT_LO = 2;
  localparam int STAT_PROT_HI = 3;
  localparam int STAT_LOCK = 7;

  typedef struct packed {
    logic status_write_lock;
    logic block_protect_hi;
    logic block_protect_lo;
  } epus_nv_s;

  typedef enum logic [1:0] {
    EPUS_STANDBY,
    EPUS_ACTIVE,
    EPUS_WRITING
  } epus_mode_e;
endpackage

// file: epus_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module epus_sync #(
  parameter logic INIT = 1'b1
) (
  input wire logic clk_in, // system clock
  input wire logic rst_n_in, // async reset, active low
  input wire logic pin_in, // asynchronous pin
  output logic level_out // filtered level
);
  logic s1;
  logic s2;
  logic s3;
  logic next_level;

  // level moves only once stages two and three agree
  always_comb begin
    next_level = level_out;
    if (s2 == s3) begin
      next_level = s3;
    end
  end

  // start value is per instance, so the owner picks what reset looks like
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      level_out <= INIT;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
      level_out <= next_level;
    end
  end
endmodule

// file: epus_monitor.sv
// checker: assertions on the power-up logic ports
`timescale 1ns/1ns
module epus_monitor #(
  parameter int WRITE_CYCLES = epus_pkg::WRITE_CYCLES
) (
  input wire logic MCLK_IN, // clock
  input wire logic RESET_N_IN, // reset
  input wire logic CHIP_SEL_N_IN, // select pin
  input wire logic [7:0] ARRAY_DATA_OUT, // read data
  input wire logic [7:0] STATUS_OUT, // status
  input wire logic STANDBY_OUT, // standby
  input wire logic SELECTED_OUT, // selected
  input wire logic HOLD_ACTIVE_OUT, // hold
  input wire logic STATUS_WR_OK_OUT // write ok
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  int busy_cnt;
  // cycles the busy bit has been seen high, for the write time
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= STATUS_OUT[0] ? busy_cnt + 1 : 0;
    end
  end
  sequence s_up; $rose(RESET_N_IN); endsequence
  sequence s_end; $fell(STATUS_OUT[0]); endsequence
  array_ones_a: assert property (ARRAY_DATA_OUT == 8'hff)
    else $error("array byte not erased");
  power_up_a: assert property (s_up |-> STANDBY_OUT && !SELECTED_OUT
    && !HOLD_ACTIVE_OUT && STATUS_OUT[1:0] == 2'h0) else $error("bad power-up");
  sel_idle_a: assert property (SELECTED_OUT |-> !STANDBY_OUT)
    else $error("standby while selected");
  hold_sel_a: assert property (HOLD_ACTIVE_OUT |-> SELECTED_OUT)
    else $error("hold while deselected");
  sel_cause_a: assert property ($rose(SELECTED_OUT)
    |-> !$past(CHIP_SEL_N_IN, 5) && !$past(CHIP_SEL_N_IN, 6))
    else $error("select without fall");
  latch_cause_a: assert property ($rose(STATUS_OUT[1])
    |-> $past(SELECTED_OUT) || $past(SELECTED_OUT, 2)) else $error("latch");
  busy_end_a: assert property (s_end |-> !STATUS_OUT[1] &&
    busy_cnt == WRITE_CYCLES) else $error("write time wrong");
  wr_ok_a: assert property ((STATUS_OUT[1] && !STATUS_OUT[7])[*3]
    |-> STATUS_WR_OK_OUT) else $error("status write blocked");
endmodule
bind epus_top epus_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) u_mon (.MCLK_IN,
  .RESET_N_IN, .CHIP_SEL_N_IN, .ARRAY_DATA_OUT, .STATUS_OUT, .STANDBY_OUT,
  .SELECTED_OUT, .HOLD_ACTIVE_OUT, .STATUS_WR_OK_OUT);

// file: epus_host.sv
// spi host model driving the select and hold pins
`timescale 1ns/1ns
module epus_host (
  input wire logic clk_in, // clock
  input wire logic sel_in, // frame wanted
  input wire logic hold_in, // pause wanted
  output logic cs_n_out, // select pin
  output logic hold_n_out // hold pin
);
  // pins lag requests by one edge, as a real host does
  initial {cs_n_out, hold_n_out} = 2'h3;
  always @(posedge clk_in) begin
    cs_n_out <= ~sel_in;
    hold_n_out <= ~hold_in;
  end
endmodule

// file: tb_top.sv
// self-checking bench for the power-up state logic
`timescale 1ns/1ns
module tb_top;
  localparam int WC = 20;
  logic clk, rst_n = 1, sel_q = 0, hold_q = 0, cs_n, hold_n, wp_n = 1;
  logic clr_l = 0;
  logic fac = 0, set_l = 0, wreq = 0, swr = 0, stby, sel, hact, wok;
  epus_pkg::epus_nv_s sd = '0;
  logic [15:0] addr = '0;
  logic [7:0] ad, st;
  int error_cnt = 0, check_count = 0, lk = 0, ph = 0, pl = 0, la = 0, n;
  epus_host host (.clk_in(clk), .sel_in(sel_q), .hold_in(hold_q),
    .cs_n_out(cs_n), .hold_n_out(hold_n));
  epus_top #(.WRITE_CYCLES(WC)) dut (.MCLK_IN(clk), .RESET_N_IN(rst_n),
    .CHIP_SEL_N_IN(cs_n), .HOLD_N_IN(hold_n), .WRITE_PROT_N_IN(wp_n),
    .FACTORY_INIT_IN(fac), .SET_LATCH_IN(set_l), .CLR_LATCH_IN(clr_l),
    .WRITE_REQ_IN(wreq), .STATUS_WR_IN(swr), .STATUS_DATA_IN(sd),
    .ARRAY_ADDR_IN(addr), .ARRAY_DATA_OUT(ad), .STATUS_OUT(st),
    .STANDBY_OUT(stby), .SELECTED_OUT(sel), .HOLD_ACTIVE_OUT(hact),
    .STATUS_WR_OK_OUT(wok));
  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // inputs always move 10 ns after the edge
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #10;
  endtask
  task automatic chk(input string nm, input logic [7:0] s, e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // model status byte; busy is never expected outside a write
  function automatic logic [7:0] ms();
    return {lk[0], 3'h0, ph[0], pl[0], la[0], 1'b0};
  endfunction
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // watchdog, far beyond the few hundred cycles needed
  initial begin
    #300000;
    error_cnt++;
    end_of_test();
  end
  // main sequence
  initial begin
    void'($urandom(32'h819cb9e3));
    // a real falling edge, so the async reset branches do run
    #10;
    rst_n = 1'b0;
    cyc(12);
    rst_n = 1'b1;
    cyc(4);
    chk("standby", stby, 1);
    chk("select", sel, 0);
    chk("hold", hact, 0);
    chk("status", st & 8'h03, 0);
    chk("array", ad, 8'hff);
    fac = 1'b1;
    cyc(1);
    fac = 1'b0;
    cyc(2);
    chk("factory", st, ms());
    // random status writes with lock and protect pin in play
    repeat (8) begin
      wp_n = 1'($urandom);
      sd = 3'($urandom);
      addr = 16'($urandom);
      sel_q = 1'b1;
      cyc(7);
      chk("select", sel, 1);
      chk("standby", stby, 0);
      chk("array", ad, 8'hff);
      set_l = 1'b1;
      cyc(1);
      set_l = 1'b0;
      la = 1;
      cyc(2);
      chk("wr ok", wok, 8'(!lk[0] | wp_n));
      swr = 1'b1;
      cyc(1);
      swr = 1'b0;
      cyc(2);
      if (!lk[0] || wp_n) {lk[0], ph[0], pl[0]} = sd;
      chk("nv", st & 8'h8c, ms() & 8'h8c);
      // random write disable while still selected
      clr_l = 1'($urandom);
      cyc(1);
      if (clr_l) la = 0;
      clr_l = 1'b0;
      cyc(2);
      chk("latch", st & 8'h02, ms() & 8'h02);
      sel_q = 1'b0;
      cyc(7);
    end
    // self-timed write, started by select rising
    sel_q = 1'b1;
    cyc(7);
    {set_l, wreq} = 2'h3;
    cyc(1);
    {set_l, sel_q} = 2'h0;
    cyc(8);
    wreq = 1'b0;
    chk("busy", st & 8'h03, 8'h03);
    n = 0;
    while (st[0] !== 1'b0 && n < 3 * WC) begin
      cyc(1);
      n++;
    end
    la = 0;
    chk("done", st & 8'h03, 0);
    // first look comes one busy cycle in, so one short of the full time
    chk("time", 8'(n), 8'(WC - 1));
    // hold while selected, then power cycle with select held low
    {sel_q, hold_q} = 2'h3;
    cyc(8);
    chk("hold", hact, 1);
    rst_n = 1'b0;
    cyc(3);
    rst_n = 1'b1;
    cyc(6);
    chk("hold", hact, 0);
    chk("select", sel, 0);
    chk("status", st, ms());
    // host raises and lowers select: only then is the device selected
    sel_q = 1'b0;
    cyc(7);
    sel_q = 1'b1;
    cyc(7);
    chk("select", sel, 1);
    end_of_test();
  end
endmodule
